// ### logic/csa_regs.vh
// Functional notes
// [R1] Six operand addressing modes are supported
// [R2] Decoder accepts only its group's modes
// [R3] A group allows six modes at most
// [R4] Bit 13 sticky on accumulator A saturation
// [R5] Bit 11 is OR of overflows
// [R6] Priority bits read-only when nesting disabled
// [R7] Clear stickies by write or combined bit
// [R8] Bits 15/14 overflow, bit 12 B sticky
`ifndef CSA_REGS_VH
`define CSA_REGS_VH
// Register byte offsets
`define CSA_OFF_STATUS 8'h00
`define CSA_OFF_CTRL 8'h04
`define CSA_OFF_IRQ_STAT 8'h08
`define CSA_OFF_IRQ_EN 8'h0C
`define CSA_OFF_IRQ_CLR 8'h10
// Status word fields
`define CSA_B_OVF_A 15
`define CSA_B_OVF_B 14
`define CSA_B_CLIP_A 13
`define CSA_B_CLIP_B 12
`define CSA_B_ANY_OVF 11
`define CSA_B_ANY_CLIP 10
`define CSA_B_LOOP 9
`define CSA_B_HALF_C 8
`define CSA_B_PRIO_HI 7
`define CSA_B_PRIO_LO 5
`define CSA_B_RPT 4
`define CSA_STATUS_RST 16'h0000
// Control and interrupt fields
`define CSA_B_NEST_DIS 0
`define CSA_IRQ_OVF 0
`define CSA_IRQ_CLIP 1
`define CSA_IRQ_BADMODE 2
`define CSA_IRQ_W 3
// Addressing mode codes
`define CSA_MODE_INHERENT 3'h0
`define CSA_MODE_RELATIVE 3'h1
`define CSA_MODE_LITERAL 3'h2
`define CSA_MODE_MEM_DIR 3'h3
`define CSA_MODE_REG_DIR 3'h4
`define CSA_MODE_REG_IND 3'h5
`define CSA_NUM_MODES 6
// Allowed-mode masks per instruction group
`define CSA_GRP0_MASK 6'h01
`define CSA_GRP1_MASK 6'h02
`define CSA_GRP2_MASK 6'h3C
`define CSA_GRP3_MASK 6'h38
`define CSA_GRP4_MASK 6'h30
`define CSA_GRP5_MASK 6'h3F
`define CSA_GRP6_MASK 6'h18
`define CSA_GRP7_MASK 6'h00
// Bus responses
`define CSA_RESP_OKAY 2'h0
`define CSA_RESP_SLVERR 2'h2
`endif

// ### logic/csa_top.v
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "csa_regs.vh"
module csa_top (
    input wire clk, // 200 MHz core clock
    input wire nrst, // Async reset, active low
    // Accumulator events from the datapath
    input wire acc_upd, // Overflow levels valid this cycle
    input wire acc_a_ovf_in, // Accumulator A overflow level
    input wire acc_b_ovf_in, // Accumulator B overflow level
    input wire acc_a_clip, // Accumulator A saturated pulse
    input wire acc_b_clip, // Accumulator B saturated pulse
    // Decoder mode check
    input wire dec_valid, // Check request strobe
    input wire [2:0] dec_group, // Instruction mode group
    input wire [2:0] dec_mode, // Requested addressing mode
    output reg dec_ok_r, // Mode accepted pulse
    output reg dec_bad_r, // Mode refused pulse
    // Status word to the core
    output reg [15:0] cpu_status_word_r, // Current status word
    output reg nesting_disable_ctl_r, // Nesting disable control
    output reg irq_r, // Level interrupt
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready // Read data ready
);

    // Reset synchroniser stages
    reg rst_meta_r;
    reg rst_n_r;
    // Captured write request
    reg [7:0] awaddr_r; // Held write address
    reg [31:0] wdata_r; // Held write data
    reg [3:0] wstrb_r; // Held strobes
    // Interrupt registers
    reg [`CSA_IRQ_W-1:0] irq_stat_r; // Sticky events
    reg [`CSA_IRQ_W-1:0] irq_en_r; // Event enables
    // Next-state values
    reg [15:0] st_nxt; // Status word next
    reg [15:0] wmask; // Byte lane mask
    reg [15:0] wval; // Merged write value
    reg [`CSA_IRQ_W-1:0] irq_stat_nxt; // Sticky next
    reg [`CSA_IRQ_W-1:0] evt; // Events this cycle
    reg [31:0] rd_nxt; // Read data mux
    reg rd_err; // Unmapped read
    reg wr_err; // Unmapped write
    reg [5:0] grp_mask; // Allowed modes of group
    reg clr_both; // Combined clip bit cleared
    reg mode_ok; // Mode check result
    wire wr_go; // Both halves held, do write
    wire wr_st; // Status word written
    wire wr_ctl; // Control written
    wire wr_en; // Enable written
    wire wr_clr; // Clear written

    // Release reset through two flops
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Write fires once address and data are both taken
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_st = wr_go && (awaddr_r == `CSA_OFF_STATUS);
    assign wr_ctl = wr_go && (awaddr_r == `CSA_OFF_CTRL);
    assign wr_en = wr_go && (awaddr_r == `CSA_OFF_IRQ_EN);
    assign wr_clr = wr_go && (awaddr_r == `CSA_OFF_IRQ_CLR);

    // Address decode for writes
    always @*
    begin
        case (awaddr_r)
            `CSA_OFF_STATUS: wr_err = 1'b0;
            `CSA_OFF_CTRL: wr_err = 1'b0;
            `CSA_OFF_IRQ_STAT: wr_err = 1'b0; // Read-only, write ignored
            `CSA_OFF_IRQ_EN: wr_err = 1'b0;
            `CSA_OFF_IRQ_CLR: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // AXI write channels, one write in flight
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSA_RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            // Address may arrive before or after data
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Answer after both halves
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `CSA_RESP_SLVERR : `CSA_RESP_OKAY;
            end
            // Reopen only once the response is taken
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read mux, unmapped answers slave error
    always @*
    begin
        rd_nxt = 32'h00000000;
        rd_err = 1'b0;
        case (s_axi_araddr)
            `CSA_OFF_STATUS: rd_nxt[15:0] = cpu_status_word_r;
            `CSA_OFF_CTRL: rd_nxt[`CSA_B_NEST_DIS] = nesting_disable_ctl_r;
            `CSA_OFF_IRQ_STAT: rd_nxt[`CSA_IRQ_W-1:0] = irq_stat_r;
            `CSA_OFF_IRQ_EN: rd_nxt[`CSA_IRQ_W-1:0] = irq_en_r;
            `CSA_OFF_IRQ_CLR: rd_nxt = 32'h00000000; // Write-only
            default: rd_err = 1'b1;
        endcase
    end

    // AXI read channel, answer one cycle after address
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CSA_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_err ? `CSA_RESP_SLVERR : `CSA_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Status word next state
    always @*
    begin
        // Only the two low byte lanes carry the word
        wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        wval = (wdata_r[15:0] & wmask) | (cpu_status_word_r & ~wmask);
        st_nxt = cpu_status_word_r;
        // [R7] combined clip cleared
        clr_both = wr_st && wmask[`CSA_B_ANY_CLIP] && !wdata_r[`CSA_B_ANY_CLIP];
        // [R8] overflow flags per accumulator
        if (acc_upd)
        begin
            // Datapath owns the overflow levels
            st_nxt[`CSA_B_OVF_A] = acc_a_ovf_in;
            st_nxt[`CSA_B_OVF_B] = acc_b_ovf_in;
        end
        else if (wr_st)
        begin
            st_nxt[`CSA_B_OVF_A] = wval[`CSA_B_OVF_A];
            st_nxt[`CSA_B_OVF_B] = wval[`CSA_B_OVF_B];
        end
        // [R7] direct write to stickies
        if (wr_st)
        begin
            st_nxt[`CSA_B_CLIP_A] = wval[`CSA_B_CLIP_A] && !clr_both;
            st_nxt[`CSA_B_CLIP_B] = wval[`CSA_B_CLIP_B] && !clr_both;
            st_nxt[`CSA_B_HALF_C] = wval[`CSA_B_HALF_C];
            st_nxt[3:0] = wval[3:0];
        end
        // [R4] sticky A, set beats clear
        if (acc_a_clip)
            st_nxt[`CSA_B_CLIP_A] = 1'b1;
        // [R8] sticky B, set beats clear
        if (acc_b_clip)
            st_nxt[`CSA_B_CLIP_B] = 1'b1;
        // [R6] priority bits locked
        if (wr_st && !nesting_disable_ctl_r)
            st_nxt[`CSA_B_PRIO_HI:`CSA_B_PRIO_LO] = wval[`CSA_B_PRIO_HI:`CSA_B_PRIO_LO];
        // [R5] combined overflow OR
        st_nxt[`CSA_B_ANY_OVF] = st_nxt[`CSA_B_OVF_A] | st_nxt[`CSA_B_OVF_B];
        // Combined clip mirrors the two stickies
        st_nxt[`CSA_B_ANY_CLIP] = st_nxt[`CSA_B_CLIP_A] | st_nxt[`CSA_B_CLIP_B];
        // Loop and repeat bits belong to other logic
        st_nxt[`CSA_B_LOOP] = 1'b0;
        st_nxt[`CSA_B_RPT] = 1'b0;
    end

    // Status word and control register
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            cpu_status_word_r <= `CSA_STATUS_RST;
            nesting_disable_ctl_r <= 1'b0;
        end
        else
        begin
            cpu_status_word_r <= st_nxt;
            if (wr_ctl && wstrb_r[0])
                nesting_disable_ctl_r <= wdata_r[`CSA_B_NEST_DIS];
        end
    end

    // Mode group table lookup
    always @*
    begin
        // [R3] six-bit mask, six modes
        case (dec_group)
            3'h0: grp_mask = `CSA_GRP0_MASK;
            3'h1: grp_mask = `CSA_GRP1_MASK;
            3'h2: grp_mask = `CSA_GRP2_MASK;
            3'h3: grp_mask = `CSA_GRP3_MASK;
            3'h4: grp_mask = `CSA_GRP4_MASK;
            3'h5: grp_mask = `CSA_GRP5_MASK;
            3'h6: grp_mask = `CSA_GRP6_MASK;
            default: grp_mask = `CSA_GRP7_MASK;
        endcase
        // [R1] only six mode codes
        if (dec_mode < `CSA_NUM_MODES)
            mode_ok = grp_mask[dec_mode];
        else
            mode_ok = 1'b0;
    end

    // [R2] accept only group modes
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            dec_ok_r <= 1'b0;
            dec_bad_r <= 1'b0;
        end
        else
        begin
            dec_ok_r <= dec_valid && mode_ok;
            dec_bad_r <= dec_valid && !mode_ok;
        end
    end

    // Interrupt events and sticky status
    always @*
    begin
        evt = {`CSA_IRQ_W{1'b0}};
        // Rising edge of the combined overflow bit
        evt[`CSA_IRQ_OVF] = st_nxt[`CSA_B_ANY_OVF] && !cpu_status_word_r[`CSA_B_ANY_OVF];
        evt[`CSA_IRQ_CLIP] = acc_a_clip || acc_b_clip;
        evt[`CSA_IRQ_BADMODE] = dec_valid && !mode_ok;
        irq_stat_nxt = irq_stat_r;
        if (wr_clr && wstrb_r[0])
            irq_stat_nxt = irq_stat_r & ~wdata_r[`CSA_IRQ_W-1:0];
        // New event wins over a clear in the same cycle
        irq_stat_nxt = irq_stat_nxt | evt;
    end

    // Interrupt registers and output
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            irq_stat_r <= {`CSA_IRQ_W{1'b0}};
            irq_en_r <= {`CSA_IRQ_W{1'b0}};
            irq_r <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_en && wstrb_r[0])
                irq_en_r <= wdata_r[`CSA_IRQ_W-1:0];
            // Registered from next values so the pin changes in the same cycle as the sticky status
            irq_r <= |(irq_stat_nxt & (wr_en && wstrb_r[0] ?
                wdata_r[`CSA_IRQ_W-1:0] : irq_en_r));
        end
    end

endmodule

// ### testbench/csa_props.sv
`timescale 1ns/1ps
module csa_chk (
    input wire clk, // Core clock
    input wire nrst, // Reset, active low
    input wire acc_upd, // Overflow load strobe
    input wire acc_a_ovf_in, // Overflow level A
    input wire acc_b_ovf_in, // Overflow level B
    input wire acc_a_clip, // Saturation pulse A
    input wire dec_valid, // Check request
    input wire [2:0] dec_group, // Mode group
    input wire [2:0] dec_mode, // Mode code
    input wire dec_ok_r, // Accept pulse
    input wire dec_bad_r, // Refuse pulse
    input wire [15:0] cpu_status_word_r, // Status word
    input wire nesting_disable_ctl_r, // Nesting disable
    input wire s_axi_awready // Idle write channel
);
    wire [15:0] sw = cpu_status_word_r; // Short alias of the status word
    // One clock domain, so shared clocking
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_DEC_ONE: assert property (dec_valid |=> dec_ok_r ^ dec_bad_r)
        else $error("decoder gave no single answer");
    AST_DEC_ALL: assert property (dec_valid && dec_group == 3'h5
        && dec_mode < 3'h6 |=> dec_ok_r)
        else $error("full group refused a mode");
    AST_DEC_MAX: assert property (dec_valid && dec_mode > 3'h5 |=> dec_bad_r)
        else $error("seventh mode code accepted");
    AST_CLIP_A: assert property (acc_a_clip |=> sw[13])
        else $error("saturation A not flagged");
    // Only a bus write may drop the sticky flag
    AST_STICKY_A: assert property (sw[13] && s_axi_awready |=> sw[13])
        else $error("sticky A dropped without write");
    AST_ANY_OVF: assert property (sw[11] == (sw[15] | sw[14]))
        else $error("combined overflow wrong");
    AST_ANY_CLIP: assert property (sw[10] == (sw[13] | sw[12]))
        else $error("combined saturation wrong");
    AST_OVF_LOAD: assert property (acc_upd |=> sw[15] == $past(acc_a_ovf_in)
        && sw[14] == $past(acc_b_ovf_in))
        else $error("overflow bits not loaded");
    AST_PRIO_RO: assert property (nesting_disable_ctl_r |=> $stable(cpu_status_word_r[7:5]))
        else $error("priority bits changed while locked");
    cover property (dec_bad_r);
    cover property (cpu_status_word_r[13] && cpu_status_word_r[12]);
    cover property (nesting_disable_ctl_r);
endmodule

// ### testbench/csa_top_tb.sv
`timescale 1ns/1ps
`include "csa_regs.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module csa_top_tb;
    logic clk = 0, nrst = 0, acc_upd = 0, acc_a_ovf_in = 0, acc_b_ovf_in = 0; // Core side
    logic acc_a_clip = 0, acc_b_clip = 0, dec_valid = 0; // Event and check strobes
    logic [2:0] dec_group = 0, dec_mode = 0; // Check request fields
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0; // Bus addresses
    logic [31:0] s_axi_wdata = 0; // Write data
    logic [3:0] s_axi_wstrb = 4'hF; // Whole word always
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0; // Write handshakes
    logic s_axi_arvalid = 0, s_axi_rready = 0; // Read handshakes
    wire dec_ok_r, dec_bad_r, nesting_disable_ctl_r, irq_r, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Handshake answers
    wire [1:0] s_axi_bresp, s_axi_rresp; // Responses
    wire [31:0] s_axi_rdata; // Read data
    wire [15:0] cpu_status_word_r; // Status word
    int errors = 0, comparisons = 0, cycles = 0, i; // Counters
    logic [5:0] j; // Request index
    logic exp_ok; // Expected verdict
    logic [5:0] masks [8] = '{`CSA_GRP0_MASK, `CSA_GRP1_MASK, `CSA_GRP2_MASK, `CSA_GRP3_MASK,
        `CSA_GRP4_MASK, `CSA_GRP5_MASK, `CSA_GRP6_MASK, `CSA_GRP7_MASK};
    csa_top dut_u (.clk, .nrst, .acc_upd, .acc_a_ovf_in, .acc_b_ovf_in, .acc_a_clip,
        .acc_b_clip, .dec_valid, .dec_group, .dec_mode, .dec_ok_r, .dec_bad_r,
        .cpu_status_word_r, .nesting_disable_ctl_r, .irq_r, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #2.5 clk = ~clk;
    // Hang guard, tests need about two hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            complete_run;
        end
    end
    task complete_run;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Address and data offered together, each dropped once taken
    // No own limit on the wait, the hang guard ends a stuck transfer
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            `CHK(s_axi_bresp, er)
        end
    endtask
    task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            `CHK(s_axi_rdata, ed)
            `CHK(s_axi_rresp, er)
        end
    endtask
    // One-cycle event: upd, ovf A, ovf B, clip A, clip B
    task automatic ev(input [4:0] v);
        begin
            @(posedge clk);
            {acc_upd, acc_a_ovf_in, acc_b_ovf_in, acc_a_clip, acc_b_clip} <= v;
            @(posedge clk);
            {acc_upd, acc_a_ovf_in, acc_b_ovf_in, acc_a_clip, acc_b_clip} <= 5'h00;
            @(posedge clk);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`CSA_OFF_STATUS, 32'h0, `CSA_RESP_OKAY);
        rd(8'hFC, 32'h0, `CSA_RESP_SLVERR);
        wr(8'hFC, 32'hFFFF, `CSA_RESP_SLVERR);
        wr(`CSA_OFF_IRQ_EN, 32'h0, `CSA_RESP_OKAY);
        // Every group against every code, back to back
        for (i = 0; i <= 64; i++)
        begin
            @(posedge clk);
            dec_valid <= (i < 64);
            dec_group <= i[5:3];
            dec_mode <= i[2:0];
            #1;
            j = i - 1;
            exp_ok = (j[2:0] < 3'h6) ? masks[j[5:3]][j[2:0]] : 1'b0;
            if (i > 0) `CHK({dec_ok_r, dec_bad_r}, {exp_ok, !exp_ok})
        end
        `CHK(irq_r, 1'b0)
        rd(`CSA_OFF_IRQ_STAT, 32'h4, `CSA_RESP_OKAY);
        wr(`CSA_OFF_IRQ_EN, 32'h7, `CSA_RESP_OKAY);
        repeat (2) @(posedge clk);
        #1 `CHK(irq_r, 1'b1)
        wr(`CSA_OFF_IRQ_CLR, 32'h4, `CSA_RESP_OKAY);
        repeat (2) @(posedge clk);
        #1 `CHK(irq_r, 1'b0)
        ev(5'h02);
        repeat (4) @(posedge clk);
        // Status port itself, not only through the bus
        `CHK(cpu_status_word_r, 16'h2400)
        rd(`CSA_OFF_STATUS, 32'h2400, `CSA_RESP_OKAY);
        `CHK(irq_r, 1'b1)
        ev(5'h01);
        rd(`CSA_OFF_STATUS, 32'h3400, `CSA_RESP_OKAY);
        wr(`CSA_OFF_STATUS, 32'h1400, `CSA_RESP_OKAY);
        rd(`CSA_OFF_STATUS, 32'h1400, `CSA_RESP_OKAY);
        wr(`CSA_OFF_STATUS, 32'h3000, `CSA_RESP_OKAY);
        rd(`CSA_OFF_STATUS, 32'h0, `CSA_RESP_OKAY);
        ev(5'h18);
        rd(`CSA_OFF_STATUS, 32'h8800, `CSA_RESP_OKAY);
        ev(5'h14);
        rd(`CSA_OFF_STATUS, 32'h4800, `CSA_RESP_OKAY);
        ev(5'h10);
        rd(`CSA_OFF_STATUS, 32'h0, `CSA_RESP_OKAY);
        rd(`CSA_OFF_IRQ_STAT, 32'h3, `CSA_RESP_OKAY);
        wr(`CSA_OFF_IRQ_CLR, 32'h7, `CSA_RESP_OKAY);
        wr(`CSA_OFF_CTRL, 32'h1, `CSA_RESP_OKAY);
        `CHK(nesting_disable_ctl_r, 1'b1)
        wr(`CSA_OFF_STATUS, 32'hE0, `CSA_RESP_OKAY);
        rd(`CSA_OFF_STATUS, 32'h0, `CSA_RESP_OKAY);
        wr(`CSA_OFF_CTRL, 32'h0, `CSA_RESP_OKAY);
        wr(`CSA_OFF_STATUS, 32'hE0, `CSA_RESP_OKAY);
        rd(`CSA_OFF_STATUS, 32'hE0, `CSA_RESP_OKAY);
        complete_run;
    end
endmodule
bind csa_top csa_chk chk_u (.clk(clk), .nrst(nrst), .acc_upd(acc_upd),
    .acc_a_ovf_in(acc_a_ovf_in), .acc_b_ovf_in(acc_b_ovf_in), .acc_a_clip(acc_a_clip),
    .dec_valid(dec_valid), .dec_group(dec_group), .dec_mode(dec_mode),
    .dec_ok_r(dec_ok_r), .dec_bad_r(dec_bad_r), .cpu_status_word_r(cpu_status_word_r),
    .nesting_disable_ctl_r(nesting_disable_ctl_r), .s_axi_awready(s_axi_awready));
